/* core/arcp_parser.sv */
// Reply FIFO and line-buffered ASCII command parser
`include "arcp_defs.svh"
`default_nettype none

module arcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `ARCP_FIFO_DEPTH
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic [AW:0]      used;

    assign used        = wr_q - rd_q;
    assign in_ready_o  = ~used[AW];
    assign out_valid_o = used != '0;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge core_clk_i)
    begin
        if (in_valid_i && in_ready_o)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid_i && in_ready_o)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_valid_o && out_ready_i)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module arcp_parser #(
    parameter int BUF_DEPTH = `ARCP_BUF_DEPTH,
    parameter int MAX_ARGS  = `ARCP_MAX_ARGS
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   rx_valid_i,
    input  wire logic [7:0]             rx_data_i,
    output logic                        rx_ready_o,
    output logic                        cmd_valid_o,
    input  wire logic                   cmd_ready_i,
    output logic      [31:0]            cmd_mnem_o,
    output logic                        cmd_query_o,
    output logic      [2:0]             cmd_nargs_o,
    output logic      [MAX_ARGS*32-1:0] cmd_args_o,
    output logic      [1:0]             cmd_chan_o,
    output logic                        cmd_err_o,
    output logic                        line_busy_o,
    input  wire logic                   rsp_valid_i,
    input  wire logic [7:0]             rsp_data_i,
    input  wire logic                   rsp_last_i,
    output logic                        rsp_ready_o,
    output logic                        tx_valid_o,
    output logic      [7:0]             tx_data_o,
    input  wire logic                   tx_ready_i
);
    localparam int PW = $clog2(BUF_DEPTH);

    logic [7:0]  buf_q [BUF_DEPTH];
    logic [PW:0] wr_ptr_q;
    logic [PW:0] rd_ptr_q;
    logic [PW:0] lines_q;
    logic [PW:0] fill;
    logic        rx_take;
    logic        rx_term;
    logic [7:0]  ch;
    logic        ch_term;
    logic        ch_digit;
    logic [31:0] ch_val;
    logic        avail;
    logic        rd_adv;

    arcp_pkg::arcp_state_t state_q;
    logic [1:0]         mcnt_q;
    logic [31:0]        mnem_q;
    logic               query_q;
    logic [2:0]         nargs_q;
    logic [31:0]        args_q [MAX_ARGS];
    logic [1:0]         chan_q;
    logic               valid_q;
    logic               err_q;
    logic [31:0]        mant_q;
    logic               neg_q;
    logic               point_q;
    logic               emode_q;
    logic               eneg_q;
    logic               any_q;
    logic signed [7:0]  frac_q;
    logic signed [7:0]  exp_q;
    logic signed [7:0]  shift_q;
    logic               last_q;

    logic [7:0] last_term_q;
    logic       term_pend_q;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic       rsp_done;

    function automatic logic [31:0] times10(input logic [31:0] v);
        times10 = {v[28:0], 3'b000} + {v[30:0], 1'b0};
    endfunction

    // Only processed characters may be overwritten
    assign fill        = wr_ptr_q - rd_ptr_q;
    assign rx_ready_o  = ~fill[PW]; // R9
    assign rx_take     = rx_valid_i & rx_ready_o;
    assign rx_term     = (rx_data_i == `ARCP_LF) || (rx_data_i == `ARCP_CR); // R3
    assign ch          = buf_q[rd_ptr_q[PW-1:0]];
    assign ch_term     = (ch == `ARCP_LF) || (ch == `ARCP_CR); // R3
    assign ch_digit    = (ch >= `ARCP_DIG0) && (ch <= `ARCP_DIG9);
    assign ch_val      = {24'h000000, ch - `ARCP_DIG0};
    assign avail       = (fill != '0) && (lines_q != '0); // R4
    assign line_busy_o = lines_q != '0;
    assign rd_adv      = avail && (state_q == arcp_pkg::ST_MNEM || state_q == arcp_pkg::ST_ARG
                                   || state_q == arcp_pkg::ST_SKIP); // R8

    always_ff @(posedge core_clk_i)
    begin
        if (rx_take)
        begin
            buf_q[wr_ptr_q[PW-1:0]] <= rx_data_i; // R8
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            lines_q     <= '0;
            last_term_q <= `ARCP_RST_TERM;
        end
        else
        begin
            if (rx_take)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1; // R9
            end
            if (rd_adv)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            // One line may arrive as another finishes in the same cycle
            if ((rx_take && rx_term) && !(rd_adv && ch_term))
            begin
                lines_q <= lines_q + 1'b1; // R4
            end
            else if (!(rx_take && rx_term) && (rd_adv && ch_term))
            begin
                lines_q <= lines_q - 1'b1;
            end
            if (rx_take && rx_term)
            begin
                last_term_q <= rx_data_i;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= arcp_pkg::ST_MNEM;
            {mcnt_q, mnem_q, query_q, nargs_q, chan_q, valid_q, err_q, last_q} <= '0;
            {mant_q, neg_q, point_q, emode_q, eneg_q, any_q, frac_q, exp_q, shift_q} <= '0;
            for (int i = 0; i < MAX_ARGS; i++)
            begin
                args_q[i] <= '0;
            end
        end
        else
        begin
            err_q <= 1'b0;
            unique case (state_q)
                arcp_pkg::ST_MNEM:
                begin
                    if (avail)
                    begin
                        if (ch_term || ch == `ARCP_SEMI || ch == `ARCP_SPACE)
                        begin
                            // Empty segments and spaces before a mnemonic pass
                            if (mcnt_q != '0)
                            begin
                                err_q  <= 1'b1; // R2
                                mcnt_q <= '0;
                            end
                        end
                        else if (ch >= `ARCP_UC_A && ch <= `ARCP_UC_Z)
                        begin
                            mnem_q <= {mnem_q[23:0], ch}; // R1
                            mcnt_q <= mcnt_q + 1'b1;
                            if (mcnt_q == `ARCP_MNEM_LAST)
                            begin
                                state_q <= arcp_pkg::ST_ARG; // R2
                                mcnt_q  <= '0;
                                query_q <= 1'b0;
                                nargs_q <= '0;
                                chan_q  <= '0;
                            end
                        end
                        else
                        begin
                            err_q   <= 1'b1; // R1
                            mcnt_q  <= '0;
                            state_q <= arcp_pkg::ST_SKIP;
                        end
                    end
                end
                arcp_pkg::ST_ARG:
                begin
                    if (avail)
                    begin
                        if (ch == `ARCP_SPACE)
                        begin
                            any_q <= any_q; // R16
                        end
                        else if (ch == `ARCP_QMARK && nargs_q == '0 && !any_q && !query_q)
                        begin
                            query_q <= 1'b1; // R10
                        end
                        else if (ch == `ARCP_COMMA || ch == `ARCP_SEMI || ch_term)
                        begin
                            last_q  <= ch != `ARCP_COMMA; // R6
                            shift_q <= `ARCP_FRAC_DIGITS - frac_q + (eneg_q ? -exp_q : exp_q);
                            if (ch == `ARCP_COMMA || any_q || nargs_q != '0)
                            begin
                                state_q <= arcp_pkg::ST_NORM; // R5
                            end
                            else
                            begin
                                state_q <= arcp_pkg::ST_ISSUE;
                                valid_q <= 1'b1;
                            end
                        end
                        else if (ch == `ARCP_MINUS)
                        begin
                            any_q <= 1'b1;
                            if (emode_q)
                            begin
                                eneg_q <= 1'b1;
                            end
                            else
                            begin
                                neg_q <= 1'b1;
                            end
                        end
                        else if (ch == `ARCP_PLUS)
                        begin
                            any_q <= 1'b1;
                        end
                        else if (ch == `ARCP_POINT)
                        begin
                            any_q   <= 1'b1;
                            point_q <= 1'b1; // R14
                        end
                        else if (ch == `ARCP_EXP_UC || ch == `ARCP_EXP_LC)
                        begin
                            any_q   <= 1'b1;
                            emode_q <= 1'b1; // R13
                        end
                        else if (ch_digit)
                        begin
                            any_q <= 1'b1;
                            if (emode_q)
                            begin
                                exp_q <= 8'(exp_q * 8'sd10 + $signed({4'h0, ch[3:0]})); // R13
                            end
                            else
                            begin
                                mant_q <= times10(mant_q) + ch_val;
                                frac_q <= frac_q + (point_q ? 8'sh01 : 8'sh00); // R14
                            end
                        end
                        else
                        begin
                            err_q   <= 1'b1;
                            state_q <= arcp_pkg::ST_SKIP;
                            // Drop the half-read number
                            {mant_q, neg_q, point_q, emode_q} <= '0;
                            {eneg_q, any_q, frac_q, exp_q}    <= '0;
                        end
                    end
                end
                arcp_pkg::ST_NORM:
                begin
                    // Scale to thousandths so all forms agree
                    if (shift_q > 0)
                    begin
                        mant_q  <= times10(mant_q); // R14
                        shift_q <= shift_q - 8'sh01;
                    end
                    else if (shift_q < 0)
                    begin
                        mant_q  <= mant_q / 32'ha;
                        shift_q <= shift_q + 8'sh01;
                    end
                    else
                    begin
                        if (nargs_q < 3'(MAX_ARGS))
                        begin
                            args_q[nargs_q[$clog2(MAX_ARGS)-1:0]] <= neg_q ? -mant_q : mant_q;
                            nargs_q <= nargs_q + 3'h1;
                        end
                        else
                        begin
                            err_q <= 1'b1;
                        end
                        if (nargs_q == '0)
                        begin
                            chan_q <= {mant_q == `ARCP_CHAN2_VAL && !neg_q,
                                       mant_q == `ARCP_CHAN1_VAL && !neg_q}; // R15
                        end
                        {mant_q, neg_q, point_q, emode_q, eneg_q, any_q, frac_q, exp_q} <= '0;
                        state_q <= last_q ? arcp_pkg::ST_ISSUE : arcp_pkg::ST_ARG;
                        valid_q <= last_q;
                    end
                end
                arcp_pkg::ST_ISSUE:
                begin
                    if (cmd_ready_i)
                    begin
                        valid_q <= 1'b0; // R6
                        state_q <= query_q ? arcp_pkg::ST_WAIT : arcp_pkg::ST_MNEM;
                    end
                end
                arcp_pkg::ST_WAIT:
                begin
                    // Next command waits for the queued reply
                    if (rsp_done)
                    begin
                        state_q <= arcp_pkg::ST_MNEM; // R12
                    end
                end
                arcp_pkg::ST_SKIP:
                begin
                    if (avail && (ch_term || ch == `ARCP_SEMI))
                    begin
                        state_q <= arcp_pkg::ST_MNEM; // R7
                    end
                end
            endcase
        end
    end

    assign cmd_valid_o = valid_q;
    assign cmd_mnem_o  = mnem_q;
    assign cmd_query_o = query_q;
    assign cmd_nargs_o = nargs_q;
    assign cmd_chan_o  = chan_q;
    assign cmd_err_o   = err_q;

    for (genvar g = 0; g < MAX_ARGS; g++)
    begin : g_args
        assign cmd_args_o[g*32 +: 32] = args_q[g];
    end

    // Terminator push stalls the executor until the FIFO accepts it
    assign fifo_in_valid = term_pend_q | rsp_valid_i;
    assign fifo_in_data  = term_pend_q ? last_term_q : rsp_data_i; // R11
    assign rsp_ready_o   = fifo_in_ready & ~term_pend_q;
    assign rsp_done      = term_pend_q & fifo_in_ready;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            term_pend_q <= 1'b0;
        end
        else if (rsp_valid_i && rsp_ready_o && rsp_last_i)
        begin
            term_pend_q <= 1'b1; // R11
        end
        else if (rsp_done)
        begin
            term_pend_q <= 1'b0; // R12
        end
    end

    arcp_fifo #(
        .WIDTH (8),
        .DEPTH (`ARCP_FIFO_DEPTH)
    ) u_reply_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o)
    );
endmodule

`default_nettype wire

/* core/arcp_defs.svh */
// Constants of the ASCII command parser
// Function
// R1: Command text is ASCII and only upper-case mnemonic letters are recognised.
// R2: A command is a four-character mnemonic, then any arguments, then a terminator.
// R3: Either a linefeed or a carriage return ends a command line.
// R4: No received character is interpreted before a terminator for its line has arrived.
// R5: Arguments are split into separate fields at each comma.
// R6: Semicolons split one line into several individual commands.
// R7: Every command of a line finishes before any command of a later line starts.
// R8: Received characters sit in a 256-character buffer and run strictly in arrival order.
// R9: When the buffer wraps, new characters overwrite the oldest already processed ones.
// R10: A question mark right after the mnemonic marks a query that reports instead of sets.
// R11: Every query reply goes back as ASCII characters closed by a terminator.
// R12: Several queries on one line return separate replies in order, each terminated.
// R13: Exponent notation is accepted, so 10E3 reads as ten thousand.
// R14: Integer, decimal and exponent forms of one number give the same value.
// R15: A channel argument of 1 selects the first channel and 2 the second.
// R16: Spaces before or between arguments are ignored when fields are split.
`ifndef ARCP_DEFS_SVH
`define ARCP_DEFS_SVH

`define ARCP_LF          8'h0a
`define ARCP_CR          8'h0d
`define ARCP_SPACE       8'h20
`define ARCP_PLUS        8'h2b
`define ARCP_COMMA       8'h2c
`define ARCP_MINUS       8'h2d
`define ARCP_POINT       8'h2e
`define ARCP_DIG0        8'h30
`define ARCP_DIG9        8'h39
`define ARCP_SEMI        8'h3b
`define ARCP_QMARK       8'h3f
`define ARCP_UC_A        8'h41
`define ARCP_EXP_UC      8'h45
`define ARCP_UC_Z        8'h5a
`define ARCP_EXP_LC      8'h65
`define ARCP_BUF_DEPTH   256
`define ARCP_FIFO_DEPTH  16
`define ARCP_MAX_ARGS    4
`define ARCP_MNEM_LAST   2'h3
`define ARCP_FRAC_DIGITS 8'sh03
`define ARCP_CHAN1_VAL   32'h3e8
`define ARCP_CHAN2_VAL   32'h7d0
`define ARCP_RST_TERM    8'h0d

`endif

/* core/arcp_pkg.sv */
// Types shared by the ASCII command parser
`default_nettype none

package arcp_pkg;

    typedef enum logic [2:0] {
        ST_MNEM,
        ST_ARG,
        ST_NORM,
        ST_ISSUE,
        ST_WAIT,
        ST_SKIP
    } arcp_state_t;

endpackage

`default_nettype wire

/* verif/arcp_parser_checker.sv */
// Concurrent checks on the command parser ports
`default_nettype none
module arcp_parser_checker #(
    parameter int MAX_ARGS = 4
) (
    input wire logic                   core_clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   rx_valid_i,
    input wire logic [7:0]             rx_data_i,
    input wire logic                   rx_ready_o,
    input wire logic                   cmd_valid_o,
    input wire logic                   cmd_ready_i,
    input wire logic [31:0]            cmd_mnem_o,
    input wire logic [2:0]             cmd_nargs_o,
    input wire logic [MAX_ARGS*32-1:0] cmd_args_o,
    input wire logic [1:0]             cmd_chan_o,
    input wire logic                   cmd_err_o,
    input wire logic                   line_busy_o,
    input wire logic                   rsp_valid_i,
    input wire logic                   rsp_last_i,
    input wire logic                   rsp_ready_o,
    input wire logic                   tx_valid_o,
    input wire logic [7:0]             tx_data_o,
    input wire logic                   tx_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    function automatic logic is_up(input logic [7:0] c);
        return c >= 8'h41 && c <= 8'h5a;
    endfunction
    logic term_in;
    assign term_in = rx_valid_i && rx_ready_o && (rx_data_i == 8'h0a || rx_data_i == 8'h0d);
    sequence s_term_in;
        term_in;
    endsequence
    sequence s_last_in;
        rsp_valid_i && rsp_ready_o && rsp_last_i;
    endsequence
    a_mnem_upper: assert property (cmd_valid_o |-> is_up(cmd_mnem_o[31:24]) &&
        is_up(cmd_mnem_o[23:16]) && is_up(cmd_mnem_o[15:8]) && is_up(cmd_mnem_o[7:0]))
        else $error("bad mnemonic");
    a_term_busy: assert property (s_term_in |=> line_busy_o)
        else $error("no line mark");
    a_busy_cause: assert property ($rose(line_busy_o) |-> $past(term_in))
        else $error("line without terminator");
    a_args_bound: assert property (cmd_valid_o |-> int'(cmd_nargs_o) <= MAX_ARGS)
        else $error("too many arguments");
    a_cmd_hold: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o &&
        $stable(cmd_mnem_o) && $stable(cmd_args_o) && $stable(cmd_nargs_o))
        else $error("command changed");
    a_chan_sel: assert property (cmd_valid_o && cmd_nargs_o != 3'h0 |->
        cmd_chan_o == (cmd_args_o[31:0] == 32'h3e8 ? 2'b01 :
        cmd_args_o[31:0] == 32'h7d0 ? 2'b10 : 2'b00))
        else $error("channel decode");
    a_err_pulse: assert property (cmd_err_o |=> !cmd_err_o)
        else $error("long error flag");
    a_term_gap: assert property (s_last_in |=> !rsp_ready_o)
        else $error("no terminator slot");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("reply char lost");
endmodule
bind arcp_parser arcp_parser_checker #(.MAX_ARGS(MAX_ARGS)) i_arcp_chk (.*);
`default_nettype wire

/* verif/arcp_host_model.sv */
// Host model: sends command lines, collects replies
`default_nettype none
module arcp_host_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    input  wire logic       rx_ready_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    input  wire logic       stall_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    int         sent = 0;
    int         limit = 3000;
    logic       hung = 1'b0;
    initial
    begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
    end
    assign tx_ready_o = !stall_i;
    always @(posedge core_clk_i)
        if (rst_n_i && tx_valid_i && tx_ready_o)
            got_q.push_back(tx_data_i);
    // Caller gives raw text in any case; the closing CR or LF may come in a later call
    task automatic send(input string s);
        int   n;
        logic ok;
        @(posedge core_clk_i);
        for (int i = 0; i < s.len() && !hung; i++)
        begin
            #1;
            rx_valid_o = 1'b1;
            rx_data_o  = s[i];
            n = 0;
            do
            begin
                @(posedge core_clk_i);
                ok = rx_ready_i;
                n++;
            end while (!ok && n < limit);
            if (ok)
                sent++;
            else
                hung = 1'b1;
        end
        #1;
        rx_valid_o = 1'b0;
        // Scrambled so no stale character is relied on
        rx_data_o  = ~rx_data_o;
    endtask
endmodule
`default_nettype wire

/* verif/arcp_parser_tb.sv */
// Self-checking bench for the ASCII command parser
`default_nettype none
module arcp_parser_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, rst_n, rx_valid, rx_ready, cmd_valid, cmd_ready, cmd_query, cmd_err;
    logic         line_busy, rsp_valid, rsp_last, rsp_ready, tx_valid, tx_ready, stall;
    logic [7:0]   rx_data, rsp_data, tx_data;
    logic [31:0]  cmd_mnem;
    logic [2:0]   cmd_nargs;
    logic [127:0] cmd_args;
    logic [1:0]   cmd_chan;
    int           err_count, checks_done, err_seen, rsp_taken, s0;
    string        s;

    arcp_parser i_arcp_parser (
        .core_clk_i(clk), .rst_n_i(rst_n), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .rx_ready_o(rx_ready), .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
        .cmd_mnem_o(cmd_mnem), .cmd_query_o(cmd_query), .cmd_nargs_o(cmd_nargs),
        .cmd_args_o(cmd_args), .cmd_chan_o(cmd_chan), .cmd_err_o(cmd_err),
        .line_busy_o(line_busy), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
        .rsp_last_i(rsp_last), .rsp_ready_o(rsp_ready), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .tx_ready_i(tx_ready)
    );
    arcp_host_model i_host (
        .core_clk_i(clk), .rst_n_i(rst_n), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .stall_i(stall)
    );
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (cmd_err === 1'b1)
            err_seen++;
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
            rsp_taken++;
    end
    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test(input logic tmo = 1'b0);
        if (i_host.hung || tmo)
            err_count++;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask
    task automatic get_cmd(input logic [31:0] m, input logic [31:0] a0, input logic [1:0] ch,
                           input logic q = 1'b0, input logic [2:0] na = 3'h1,
                           input logic [31:0] a1 = 32'h0);
        int n = 0;
        while (cmd_valid !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 3000)
            stop_test(1'b1);
        chk("command", {cmd_mnem, cmd_query, cmd_nargs, cmd_chan}, {m, q, na, ch});
        chk("arg0", cmd_args[31:0], a0);
        if (na > 3'h1)
            chk("arg1", cmd_args[63:32], a1);
        cmd_ready = 1'b1;
        @(posedge clk);
        #1;
        cmd_ready = 1'b0;
    endtask
    task automatic reply(input string r);
        int   n;
        logic ok;
        for (int i = 0; i < r.len(); i++)
        begin
            #1;
            rsp_valid = 1'b1;
            rsp_data  = r[i];
            rsp_last  = (i == r.len() - 1);
            n = 0;
            do
            begin
                @(posedge clk);
                ok = (rsp_ready === 1'b1);
                n++;
            end while (!ok && n < 3000);
            if (!ok)
                stop_test(1'b1);
        end
        #1;
        rsp_valid = 1'b0;
    endtask
    task automatic expect_host(input string e);
        int n = 0;
        while (i_host.got_q.size() < e.len() && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        chk("reply length", i_host.got_q.size(), e.len());
        for (int i = 0; i < e.len() && i < i_host.got_q.size(); i++)
            chk("reply char", i_host.got_q[i], e[i]);
        i_host.got_q.delete();
    endtask
    task automatic t_forms();
        i_host.send("FMOD1\rFREQ10E3;FREQ5.0;FREQ .5E1,2\n");
        get_cmd("FMOD", 32'h3e8, 2'b01);
        get_cmd("FREQ", 32'h989680, 2'b00);
        get_cmd("FREQ", 32'h1388, 2'b00);
        get_cmd("FREQ", 32'h1388, 2'b00, 1'b0, 3'h2, 32'h7d0);
    endtask
    task automatic t_hold();
        i_host.send("FMOD 2;SLVL1");
        repeat (30) @(posedge clk);
        chk("no line yet", {line_busy, cmd_valid}, 2'b00);
        i_host.send("\rPHAS1\r");
        get_cmd("FMOD", 32'h7d0, 2'b10);
        get_cmd("SLVL", 32'h3e8, 2'b01);
        get_cmd("PHAS", 32'h3e8, 2'b01);
    endtask
    task automatic t_query();
        i_host.send("OUTP?1;OUTP?2\n");
        get_cmd("OUTP", 32'h3e8, 2'b01, 1'b1);
        reply("A");
        get_cmd("OUTP", 32'h7d0, 2'b10, 1'b1);
        reply("BC");
        expect_host("A\nBC\n");
    endtask
    task automatic t_err();
        s0 = err_seen;
        i_host.send("fmod1;FMOD2\r");
        get_cmd("FMOD", 32'h7d0, 2'b10);
        chk("syntax error", err_seen - s0, 1);
    endtask
    task automatic t_fifo();
        i_host.send("OUTP?2\r");
        get_cmd("OUTP", 32'h7d0, 2'b10, 1'b1);
        stall = 1'b1;
        s0 = rsp_taken;
        fork
            reply("ABCDEFGHIJKLMNOPQRST");
            begin
                repeat (60) @(posedge clk);
                chk("queue fill", rsp_taken - s0, 16);
                chk("queue full", {tx_valid, rsp_ready}, 2'b10);
                chk("host idle", i_host.got_q.size(), 0);
                #1;
                stall = 1'b0;
            end
        join
        expect_host("ABCDEFGHIJKLMNOPQRST\r");
    endtask
    task automatic t_full();
        repeat (45)
        begin
            i_host.send("FMOD2\r");
            get_cmd("FMOD", 32'h7d0, 2'b10);
        end
        s = "";
        repeat (260) s = {s, "A"};
        i_host.limit = 40;
        s0 = i_host.sent;
        i_host.send(s);
        chk("buffer room", i_host.sent - s0, 256);
        chk("buffer full", rx_ready, 1'b0);
        i_host.limit = 3000;
        i_host.hung = 1'b0;
        do_reset();
        chk("ready after reset", {rx_ready, line_busy, cmd_valid}, 3'b100);
    endtask
    initial
    begin
        cmd_ready = 1'b0;
        rsp_valid = 1'b0;
        rsp_last  = 1'b0;
        rsp_data  = 8'h00;
        stall     = 1'b0;
        do_reset();
        chk("reset state", {rx_ready, cmd_valid, line_busy, rsp_ready, tx_valid}, 5'b10010);
        t_forms();
        t_hold();
        t_query();
        t_err();
        t_fifo();
        t_full();
        stop_test();
    end
endmodule
`default_nettype wire
